//--- inc/dpw_pkg.sv
// dpw_pkg: constants and carrier types for the parallel dac port controller
// assumes a 10 MHz system clock and a latched-interface dac on the pins
package dpw_pkg;
	localparam int unsigned CLOCK_HZ       = 10_000_000;
	localparam int unsigned DATA_WIDTH     = 12;
	// least select-low time per access, ns
	localparam int unsigned SELECT_LOW_NS  = 17;
	// least select-high recovery between accesses, ns
	localparam int unsigned SELECT_HIGH_NS = 17;
	localparam int unsigned CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
	localparam int unsigned SELECT_LOW_RAW =
		(SELECT_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned SELECT_LOW_CYCLES =
		(SELECT_LOW_RAW < 1) ? 1 : SELECT_LOW_RAW;
	localparam int unsigned SELECT_HIGH_RAW =
		(SELECT_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned SELECT_HIGH_CYCLES =
		(SELECT_HIGH_RAW < 1) ? 1 : SELECT_HIGH_RAW;
	localparam int unsigned WAIT_STATES    = 1;
	localparam int unsigned COUNT_WIDTH    = 4;
	// stages on the read-back data lines
	localparam int unsigned SYNC_STAGES    = 3;
	// read cycles after which an unsettled bus is taken as it stands
	localparam int unsigned SAMPLE_LIMIT   = 12;
	localparam logic [DATA_WIDTH-1:0] CODE_RESET = 12'h000;

	typedef struct packed {
		logic                  valid;
		logic                  read;
		logic [DATA_WIDTH-1:0] code;
	} dpw_request_t;

	typedef struct packed {
		logic                  done;
		logic                  read;
		logic [DATA_WIDTH-1:0] code;
	} dpw_answer_t;

	typedef struct packed {
		logic                  select_n;
		logic                  read_not_write;
		logic [DATA_WIDTH-1:0] data_out;
		logic                  data_oe;
	} dpw_pins_t;
endpackage

//--- rtl/dpw_sync.sv
// dpw_sync: three-stage synchroniser for the data lines read back from the dac
// assumes the inputs are asynchronous to clock; stable marks agreeing stages
`timescale 1ns/1ps
`default_nettype none
module dpw_sync #(
	parameter int unsigned WIDTH = 12
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out,
	output var  logic             stable
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
	} dpw_sync_state_t;

	dpw_sync_state_t state;
	dpw_sync_state_t next_state;

	always_comb begin
		next_state    = state;
		next_state.s1 = async_in;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// s1 is looked at by s2 only
	assign sync_out = state.s3;
	assign stable   = (state.s2 == state.s3);
endmodule // dpw_sync
`default_nettype wire

//--- rtl/dpw_host.sv
// dpw_host: controller that writes and reads back a parallel-port dac
// assumes one request at a time from user logic; the dac pins sit on one
// shared data bus resolved outside from data_oe
// a read whose bus never settles returns the last synchronised word
`timescale 1ns/1ps
`default_nettype none
// How it works
// - whole code moves in one access
// - write: select and read-not-write both low
// - every write gets falling and rising select
// - read: read-not-write high, select low
// - insert one wait state per access
module dpw_host #(
	parameter int unsigned WIDTH       = dpw_pkg::DATA_WIDTH,
	parameter int unsigned WAIT_STATES = dpw_pkg::WAIT_STATES
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire dpw_pkg::dpw_request_t request,
	output var  logic                 ready,
	output var  dpw_pkg::dpw_answer_t answer,
	output var  logic                 select_n,
	output var  logic                 read_not_write,
	output var  logic [WIDTH-1:0]     data_out,
	output var  logic                 data_oe,
	input  wire logic [WIDTH-1:0]     data_in
);
	// select low per write, and before a read starts sampling: the dac minimum plus the wait states
	localparam int unsigned LOW_CYCLES   =
		dpw_pkg::SELECT_LOW_CYCLES + WAIT_STATES;
	localparam int unsigned HIGH_CYCLES  = dpw_pkg::SELECT_HIGH_CYCLES;
	localparam int unsigned SYNC_CYCLES  = dpw_pkg::SYNC_STAGES;
	localparam int unsigned SAMPLE_LIMIT = dpw_pkg::SAMPLE_LIMIT;
	localparam int unsigned COUNT_LIMIT  = 1 << dpw_pkg::COUNT_WIDTH;

	// refuse settings that the port logic cannot serve
	if (WIDTH != 8 && WIDTH != 10 && WIDTH != 12) begin : g_chk_width
		$error("dpw_host: WIDTH must be 8, 10 or 12");
	end
	if (WIDTH > dpw_pkg::DATA_WIDTH) begin : g_chk_carrier
		$error("dpw_host: WIDTH exceeds carrier width");
	end
	if (LOW_CYCLES >= COUNT_LIMIT) begin : g_chk_low
		$error("dpw_host: WAIT_STATES too large for counter");
	end
	if (HIGH_CYCLES >= COUNT_LIMIT) begin : g_chk_high
		$error("dpw_host: select recovery does not fit counter");
	end
	if (SAMPLE_LIMIT >= COUNT_LIMIT) begin : g_chk_sample
		$error("dpw_host: read limit does not fit counter");
	end
	// the limit must leave the synchroniser time to fill
	if (SAMPLE_LIMIT < SYNC_CYCLES + 1) begin : g_chk_limit
		$error("dpw_host: read limit shorter than synchroniser");
	end

	typedef enum logic [2:0] {
		IDLE,
		SETUP,
		LOW,
		SAMPLE,
		RECOVER
	} dpw_phase_t;

	typedef struct packed {
		dpw_phase_t                       phase;
		// times LOW, SAMPLE and RECOVER; cleared on every change of phase
		logic [dpw_pkg::COUNT_WIDTH-1:0]  count;
		logic                             read;
		logic                             select_n;
		logic                             read_not_write;
		logic [WIDTH-1:0]                 data_out;
		logic                             data_oe;
		logic                             ready;
		dpw_pkg::dpw_answer_t             answer;
	} dpw_host_state_t;

	dpw_host_state_t state;
	dpw_host_state_t next_state;

	// pins idle with select and read-not-write high and the bus let go
	localparam dpw_host_state_t STATE_RESET = '{
		phase:          IDLE,
		count:          '0,
		read:           1'b0,
		select_n:       1'b1,
		read_not_write: 1'b1,
		data_out:       '0,
		data_oe:        1'b0,
		ready:          1'b1,
		answer:         '{
			done: 1'b0,
			read: 1'b0,
			code: dpw_pkg::CODE_RESET
		}
	};

	logic [WIDTH-1:0] bus_sync;
	logic             bus_stable;

	dpw_sync #(
		.WIDTH (WIDTH)
	) u_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in (data_in),
		.sync_out (bus_sync),
		.stable   (bus_stable)
	);

	// end points of the timed phases, named apart from the state walk
	logic low_last;
	logic sample_settled;
	logic sample_expired;
	logic sample_take;
	logic recover_last;

	assign low_last       = state.count ==
		dpw_pkg::COUNT_WIDTH'(LOW_CYCLES - 1);
	// stages two and three agree once the word has crossed all three
	assign sample_settled = bus_stable && state.count >=
		dpw_pkg::COUNT_WIDTH'(SYNC_CYCLES - 1);
	// a bus that never settles still ends the read instead of hanging
	assign sample_expired = state.count ==
		dpw_pkg::COUNT_WIDTH'(SAMPLE_LIMIT - 1);
	assign sample_take    = sample_settled || sample_expired;
	assign recover_last   = state.count ==
		dpw_pkg::COUNT_WIDTH'(HIGH_CYCLES - 1);

	always_comb begin
		next_state             = state;
		next_state.answer.done = 1'b0;
		case (state.phase)
			IDLE: begin
				// valid is only looked at here: a busy port drops it
				if (request.valid) begin
					next_state.ready          = 1'b0;
					next_state.read           = request.read;
					next_state.read_not_write = request.read;
					// whole word at once, no byte split
					next_state.data_out = request.code[WIDTH-1:0];
					// release bus before a read so the dac may drive it
					next_state.data_oe  = !request.read;
					next_state.phase    = SETUP;
				end
			end

			SETUP: begin
				// select falls one cycle after rnw and data settle
				next_state.select_n = 1'b0;
				next_state.count    = '0;
				next_state.phase    = LOW;
			end

			LOW: begin
				next_state.count = state.count + 1'b1;
				// stretched by the wait states for the dac access time
				if (low_last) begin
					next_state.count = '0;
					if (state.read) begin
						next_state.phase = SAMPLE;
					end else begin
						// rising edge loads the dac register
						next_state.select_n = 1'b1;
						next_state.phase    = RECOVER;
					end
				end
			end

			SAMPLE: begin
				// hold select low until the synchronised bus settles or the read limit runs out
				next_state.count = state.count + 1'b1;
				if (sample_take) begin
					next_state.answer.code = '0;
					next_state.answer.code[WIDTH-1:0] = bus_sync;
					next_state.select_n = 1'b1;
					next_state.count    = '0;
					next_state.phase    = RECOVER;
				end
			end

			RECOVER: begin
				next_state.count = state.count + 1'b1;
				// the bus is let go only once select has recovered
				if (recover_last) begin
					next_state.read_not_write = 1'b1;
					next_state.data_oe        = 1'b0;
					next_state.answer.done    = 1'b1;
					next_state.answer.read    = state.read;
					// a write answers with the word the dac latched
					if (!state.read) begin
						next_state.answer.code = '0;
						next_state.answer.code[WIDTH-1:0] = state.data_out;
					end
					next_state.ready = 1'b1;
					next_state.count = '0;
					next_state.phase = IDLE;
				end
			end

			default: begin
				next_state.phase = IDLE;
			end
		endcase
	end

	// reset loads constants only; the dac keeps its own code
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// every pin and status comes straight from the state register
	assign ready          = state.ready;
	assign answer         = state.answer;
	assign select_n       = state.select_n;
	assign read_not_write = state.read_not_write;
	assign data_out       = state.data_out;
	assign data_oe        = state.data_oe;
endmodule // dpw_host
`default_nettype wire

//--- verification/dpw_host_assertions.sv
// dpw_host_assertions: pin-timing checks on the dac port controller
// assumes bind onto dpw_host with one clock and async active-low reset
`timescale 1ns/1ps
`default_nettype none
module dpw_host_assertions #(
	parameter int unsigned WIDTH = 12
) (
	input wire logic                  clock,
	input wire logic                  reset_n,
	input wire dpw_pkg::dpw_request_t request,
	input wire logic                  ready,
	input wire dpw_pkg::dpw_answer_t  answer,
	input wire logic                  select_n,
	input wire logic                  read_not_write,
	input wire logic [WIDTH-1:0]      data_out,
	input wire logic                  data_oe,
	input wire logic [WIDTH-1:0]      data_in
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	AST_WRITE_DRIVES: assert property (
		!select_n && !read_not_write |-> data_oe)
		else $error("bus not driven in write");
	AST_READ_RELEASED: assert property (
		!select_n && read_not_write |-> !data_oe)
		else $error("bus driven in read");
	AST_WORD_STEADY: assert property (
		!select_n && !read_not_write |-> $stable(data_out))
		else $error("word moved under select");
	AST_WAIT_STATE: assert property (
		$fell(select_n) && !read_not_write |-> ##1 !select_n ##1 select_n)
		else $error("write select width wrong");
	AST_RISE_DONE: assert property (
		$rose(select_n) |=> answer.done)
		else $error("no done after select rise");
	AST_RNW_STEADY: assert property (
		!select_n |-> $stable(read_not_write))
		else $error("read-not-write moved under select");
	AST_HOLD_AT_RISE: assert property (
		$rose(select_n) && !read_not_write |-> data_oe && $stable(data_out))
		else $error("word not held at select rise");
endmodule // dpw_host_assertions
bind dpw_host dpw_host_assertions #(.WIDTH(WIDTH)) u_chk (
	.clock(clock), .reset_n(reset_n), .request(request), .ready(ready),
	.answer(answer), .select_n(select_n), .read_not_write(read_not_write),
	.data_out(data_out), .data_oe(data_oe), .data_in(data_in));
`default_nettype wire

//--- verification/dpw_dac_model.sv
// dpw_dac_model: behavioural latched-interface dac on the parallel pins
// assumes the bench resolves the shared data bus from both enables
`timescale 1ns/1ps
`default_nettype none
module dpw_dac_model (
	input  wire logic        select_n,
	input  wire logic        read_not_write,
	input  wire logic [11:0] bus,
	output var  logic [11:0] drive,
	output var  logic        drive_oe
);
	// power-up clears the register
	logic [11:0] dac_reg = 12'h000;
	always @(posedge select_n)
		if (!read_not_write)
			dac_reg <= bus;
	always_comb drive_oe = !select_n && read_not_write;
	always_comb drive = dac_reg;
endmodule // dpw_dac_model
`default_nettype wire

//--- verification/testbench.sv
// testbench: random writes and read-backs against an integer dac model
// assumes dpw_host defaults and the dac model on a resolved bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                  clock = 1'b0;
	logic                  reset_n = 1'b0;
	dpw_pkg::dpw_request_t request = '0;
	dpw_pkg::dpw_answer_t  answer;
	logic                  ready, select_n, rnw, data_oe, dac_oe;
	logic [11:0]           data_out, dac_drive, bus;
	int                    n_mismatch = 0;
	int                    checks_done = 0;
	int                    seed = 27;
	int                    model = 0;
	// released bus shows the inverse so a stale read cannot pass
	assign bus = dac_oe ? dac_drive : (data_oe ? data_out : ~data_out);
	dpw_host u_dpw_host (.clock(clock), .reset_n(reset_n),
		.request(request), .ready(ready), .answer(answer),
		.select_n(select_n), .read_not_write(rnw), .data_out(data_out),
		.data_oe(data_oe), .data_in(bus));
	dpw_dac_model u_dpw_dac_model (.select_n(select_n),
		.read_not_write(rnw), .bus(bus), .drive(dac_drive),
		.drive_oe(dac_oe));
	initial forever #50 clock = ~clock;
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic access(input logic rd, input logic [11:0] code);
		int n;
		@(negedge clock);
		request = '{valid: 1'b1, read: rd, code: code};
		@(negedge clock);
		request.valid = 1'b0;
		check("ready while busy", 12'h000, {11'h000, ready});
		for (n = 0; n < 20 && answer.done !== 1'b1; n++)
			@(posedge clock) #1;
		if (n == 20) begin
			n_mismatch++;
			finish_test();
		end
		if (!rd)
			model = code;
		check("answer", model[11:0], answer.code);
		check("answer read", {11'h000, rd}, {11'h000, answer.read});
		check("ready at done", 12'h001, {11'h000, ready});
		check("dac register", model[11:0], u_dpw_dac_model.dac_reg);
	endtask
	initial begin
		repeat (3) @(negedge clock);
		reset_n = 1'b1;
		access(1'b1, 12'h000);
		access(1'b0, 12'hfff);
		access(1'b1, 12'h000);
		access(1'b0, 12'h000);
		repeat (30) access(1'($random(seed)), 12'($random(seed)));
		// reset between accesses: pins idle, the dac keeps its code
		@(negedge clock);
		reset_n = 1'b0;
		@(negedge clock);
		check("pins after reset", 12'h00d,
			{8'h00, select_n, rnw, data_oe, ready});
		reset_n = 1'b1;
		access(1'b1, 12'h000);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
